// ### verilog/pwmg_cfg.svh
// Offsets, field positions, reset values and timing counts of the PWM channel
`ifndef PWMG_CFG_SVH
`define PWMG_CFG_SVH
`define PWMG_A_BLANK      8'h00
`define PWMG_A_CTRL       8'h04
`define PWMG_A_PERIOD     8'h08
`define PWMG_A_DUTY       8'h0C
`define PWMG_A_PHASE      8'h10
`define PWMG_A_STAT       8'h14
`define PWMG_B_HRISE      15
`define PWMG_B_HFALL      14
`define PWMG_B_LRISE      13
`define PWMG_B_LFALL      12
`define PWMG_B_FLTBLK     11
`define PWMG_B_CLBLK      10
`define PWMG_B_DUR_HI     9
`define PWMG_B_DUR_LO     3
`define PWMG_BLANK_WMASK  16'hFFF8
`define PWMG_RST_BLANK    16'h0000
`define PWMG_RST_CTRL     10'h000
`define PWMG_RST_PERIOD   16'hFFFF
`define PWMG_RST_DUTY     16'h0000
`define PWMG_RST_PHASE    16'h0000
`define PWMG_STEP_NS      8
`define PWMG_CLK_NS       50
`define PWMG_NS_W         10
`endif

// ### verilog/pwmg_pkg.sv
// Types shared by the PWM channel design
package pwmg_pkg;
   typedef enum logic [1:0] {
      PWMG_PAIR_COMP  = 2'b00,
      PWMG_PAIR_INDEP = 2'b01,
      PWMG_PAIR_PP    = 2'b10,
      PWMG_PAIR_RSV   = 2'b11
   } pwmg_pair_e;

   typedef struct packed {
      logic [1:0] faultData;
      logic       faultEn;
      logic       curResetEn;
      logic       curLimitEn;
      logic       indepTb;
      logic       phaseEn;
      pwmg_pair_e pairMode;
      logic       enable;
   } pwmg_ctrl_s;

   typedef struct packed {
      logic       hRise;
      logic       hFall;
      logic       lRise;
      logic       lFall;
      logic       fltBlank;
      logic       clBlank;
      logic [6:0] duration;
      logic [2:0] unused;
   } pwmg_blank_s;

   typedef logic [15:0] pwmg_cnt_t;
endpackage

// ### verilog/pwmg_gen.sv
// One PWM generator channel with leading edge blanking and Wishbone registers
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pwmg_cfg.svh"

module pwmg_gen (
   input  wire logic                sys_clk,
   input  wire logic                arst_n,
   input  wire logic                ce,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output var  logic [31:0]         wb_dat_o,
   output var  logic                wb_ack_o,
   input  wire logic                ptmrMatch,
   input  wire logic                faultPin,
   input  wire logic                curLimitPin,
   input  wire logic                curResetPin,
   output var  logic                highSideOutput,
   output var  logic                lowSideOutput
);
   import pwmg_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   pwmg_blank_s blank_q;
   pwmg_ctrl_s  ctrl_q;
   pwmg_cnt_t   period_q;
   pwmg_cnt_t   duty_q;
   pwmg_cnt_t   phase_q;
   pwmg_cnt_t   cnt_q;
   pwmg_cnt_t   cnt_d;
   logic [`PWMG_NS_W-1:0] blankNs_q;
   logic [`PWMG_NS_W-1:0] blankNs_d;
   logic [`PWMG_NS_W-1:0] durNs;
   logic [2:0]  pinMeta_q;
   logic [2:0]  pinSync_q;
   logic        rstPin_q;
   logic        ppPhase_q;
   logic        clTrunc_q;
   logic        hPrev_q;
   logic        lPrev_q;

   // Bus decode
   wire         wbReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire         wbWr   = wbReq && wb_we_i;
   wire         selBlk = wb_adr_i == `PWMG_A_BLANK;
   wire         selCtl = wb_adr_i == `PWMG_A_CTRL;
   wire         selPer = wb_adr_i == `PWMG_A_PERIOD;
   wire         selDut = wb_adr_i == `PWMG_A_DUTY;
   wire         selPha = wb_adr_i == `PWMG_A_PHASE;
   wire         selSta = wb_adr_i == `PWMG_A_STAT;
   wire [15:0]  laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0]  wrLow    = wb_dat_i[15:0] & laneMask;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [15:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   wire [15:0]  blankWr = merge(blank_q, wrLow,
                                laneMask & `PWMG_BLANK_WMASK);
   wire [15:0]  ctrlWr  = merge({6'h00, ctrl_q}, wrLow, laneMask);
   wire [15:0]  stat    = {11'h000, clTrunc_q, ppPhase_q,
                           (blankNs_q != '0), lowSideOutput,
                           highSideOutput};

   wire [15:0]  rdMux =
      selBlk ? {blank_q[15:3], 3'h0} :
      selCtl ? {6'h00, ctrl_q} :
      selPer ? period_q :
      selDut ? duty_q :
      selPha ? phase_q :
      selSta ? stat : 16'h0000;

   // Register file; writes are taken in the cycle the ack is raised
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         blank_q  <= `PWMG_RST_BLANK;
         ctrl_q   <= `PWMG_RST_CTRL;
         period_q <= `PWMG_RST_PERIOD;
         duty_q   <= `PWMG_RST_DUTY;
         phase_q  <= `PWMG_RST_PHASE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_o <= wbReq;
         wb_dat_o <= {16'h0000, rdMux};
         if (wbWr && selBlk) blank_q  <= blankWr;
         if (wbWr && selCtl) ctrl_q   <= ctrlWr[9:0];
         if (wbWr && selPer) period_q <= merge(period_q, wrLow, laneMask);
         if (wbWr && selDut) duty_q   <= merge(duty_q, wrLow, laneMask);
         if (wbWr && selPha) phase_q  <= merge(phase_q, wrLow, laneMask);
      end
   end

   // Pin inputs: first stage is read only by the second
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinMeta_q <= 3'h0;
         pinSync_q <= 3'h0;
      end else if (ce) begin
         pinMeta_q <= {curResetPin, curLimitPin, faultPin};
         pinSync_q <= pinMeta_q;
      end
   end

   wire faultSync = pinSync_q[0];
   wire clSync    = pinSync_q[1];
   wire resetSync = pinSync_q[2];

   // Time base
   wire pwmRaw   = ctrl_q.enable && (cnt_q <= duty_q);
   wire resetReq = ctrl_q.curResetEn && resetSync && !rstPin_q
                   && (cnt_q > duty_q);
   wire indepEnd = ctrl_q.indepTb && (cnt_q >= phase_q);
   wire overPer  = !ctrl_q.indepTb && (cnt_q > period_q);
   wire syncLoad = !ctrl_q.indepTb && ptmrMatch;
   wire cycStart = ctrl_q.enable &&
                   (indepEnd || syncLoad || overPer || resetReq);

   always_comb begin
      if (!ctrl_q.enable)
         cnt_d = '0;
      else if (indepEnd)
         cnt_d = '0;
      else if (syncLoad)
         cnt_d = ctrl_q.phaseEn ? phase_q : '0;
      else if (overPer || resetReq)
         cnt_d = '0;
      else
         cnt_d = cnt_q + 16'h0001;
   end

   // Blanking: remaining time kept in ns so the 8 ns steps round up
   assign durNs = {blank_q.duration, 3'b000};
   wire hRose = highSideOutput && !hPrev_q;
   wire hFell = !highSideOutput && hPrev_q;
   wire lRose = lowSideOutput && !lPrev_q;
   wire lFell = !lowSideOutput && lPrev_q;
   wire blankTrig = (blank_q.hRise && hRose) ||
                    (blank_q.hFall && hFell) ||
                    (blank_q.lRise && lRose) ||
                    (blank_q.lFall && lFell);
   wire blanking  = blankNs_q != '0;

   always_comb begin
      if (blankTrig)
         blankNs_d = durNs;
      else if (blankNs_q > `PWMG_NS_W'(`PWMG_CLK_NS))
         blankNs_d = blankNs_q - `PWMG_NS_W'(`PWMG_CLK_NS);
      else
         blankNs_d = '0;
   end

   wire faultAct = ctrl_q.faultEn && faultSync &&
                   !(blank_q.fltBlank && blanking);
   wire clAct    = ctrl_q.curLimitEn && clSync &&
                   !(blank_q.clBlank && blanking);
   // Limit event in the start cycle still truncates the new cycle
   wire clHold   = clAct || (clTrunc_q && !cycStart);
   wire ovr      = faultAct || clHold;

   // Pair arrangement; one duty serves both push-pull phases
   wire ppNext   = cycStart ? !ppPhase_q : ppPhase_q;
   logic hsGen;
   logic lsGen;
   always_comb begin
      unique case (ctrl_q.pairMode)
         PWMG_PAIR_COMP: begin
            hsGen = pwmRaw;
            lsGen = ctrl_q.enable && !pwmRaw;
         end
         PWMG_PAIR_INDEP: begin
            hsGen = pwmRaw;
            lsGen = pwmRaw;
         end
         PWMG_PAIR_PP: begin
            hsGen = pwmRaw && !ppPhase_q;
            lsGen = pwmRaw && ppPhase_q;
         end
         default: begin
            hsGen = 1'b0;
            lsGen = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q          <= '0;
         blankNs_q      <= '0;
         rstPin_q       <= 1'b0;
         ppPhase_q      <= 1'b0;
         clTrunc_q      <= 1'b0;
         hPrev_q        <= 1'b0;
         lPrev_q        <= 1'b0;
         highSideOutput <= 1'b0;
         lowSideOutput  <= 1'b0;
      end else if (ce) begin
         cnt_q          <= cnt_d;
         blankNs_q      <= blankNs_d;
         rstPin_q       <= resetSync;
         ppPhase_q      <= ctrl_q.enable && ppNext;
         clTrunc_q      <= clHold;
         hPrev_q        <= highSideOutput;
         lPrev_q        <= lowSideOutput;
         highSideOutput <= ovr ? ctrl_q.faultData[1] : hsGen;
         lowSideOutput  <= ovr ? ctrl_q.faultData[0] : lsGen;
      end
   end

   // Checks
   property p_blank_high;
      ce && blank_q.hRise && hRose && durNs != '0
         |=> blanking ##1 (!$past(ce) || $past(blankTrig)
                 || $past(durNs, 2) <= `PWMG_NS_W'(`PWMG_CLK_NS)
                 || blankNs_q == $past(durNs, 2)
                    - `PWMG_NS_W'(`PWMG_CLK_NS));
   endproperty
   a_blank_high: assert property (p_blank_high)
      else $error("High rising edge did not start blanking");

   property p_blank_low;
      ce && blank_q.lFall && lFell |=> blankNs_q == $past(durNs);
   endproperty
   a_blank_low: assert property (p_blank_low)
      else $error("Low falling edge did not load blanking");

   property p_fault_mask;
      blank_q.fltBlank && blanking |-> !faultAct;
   endproperty
   a_fault_mask: assert property (p_fault_mask)
      else $error("Fault acted inside the blanking interval");

   property p_cl_mask;
      ctrl_q.curLimitEn && clSync && !(blank_q.clBlank && blanking)
         |-> clAct;
   endproperty
   a_cl_mask: assert property (p_cl_mask)
      else $error("Current limit lost outside blanking");

   property p_rsv;
      selBlk && wbReq && !wb_we_i && ce |=> wb_dat_o[2:0] == 3'h0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("Blanking reserved bits read nonzero");

   property p_duty;
      ce && ctrl_q.enable && !ovr && ctrl_q.pairMode == PWMG_PAIR_COMP
         |=> highSideOutput == ($past(cnt_q) <= $past(duty_q));
   endproperty
   a_duty: assert property (p_duty)
      else $error("High output disagrees with duty compare");

   property p_comp;
      ce && ctrl_q.enable && !ovr && ctrl_q.pairMode == PWMG_PAIR_COMP
         |=> lowSideOutput != highSideOutput;
   endproperty
   a_comp: assert property (p_comp)
      else $error("Low output not complement of high");

   property p_wrap;
      ce && ctrl_q.enable && overPer && !syncLoad |=> cnt_q == '0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Counter did not restart after period");

   property p_pp;
      ce && ctrl_q.pairMode == PWMG_PAIR_PP && !ovr
         |=> !(highSideOutput && lowSideOutput);
   endproperty
   a_pp: assert property (p_pp)
      else $error("Push-pull drove both outputs");

   property p_cl_hold;
      ce && clTrunc_q && !cycStart && !faultAct
         |=> clTrunc_q && highSideOutput == $past(ctrl_q.faultData[1]);
   endproperty
   a_cl_hold: assert property (p_cl_hold)
      else $error("Truncation released before cycle start");

   property p_indep;
      ce && ctrl_q.enable && indepEnd |=> cnt_q == '0;
   endproperty
   a_indep: assert property (p_indep)
      else $error("Independent base did not restart at phase");

   property p_blank_hfall;
      ce && blank_q.hFall && hFell |=> blankNs_q == $past(durNs);
   endproperty
   a_blank_hfall: assert property (p_blank_hfall)
      else $error("High falling edge did not load blanking");

   property p_blank_lrise;
      ce && blank_q.lRise && lRose |=> blankNs_q == $past(durNs);
   endproperty
   a_blank_lrise: assert property (p_blank_lrise)
      else $error("Low rising edge did not load blanking");

   property p_blank_down;
      ce && blanking && !blankTrig |=> blankNs_q < $past(blankNs_q);
   endproperty
   a_blank_down: assert property (p_blank_down)
      else $error("Blanking time did not run down");

   property p_phase_load;
      ce && ctrl_q.enable && syncLoad
         |=> cnt_q == ($past(ctrl_q.phaseEn) ? $past(phase_q) : 16'h0000);
   endproperty
   a_phase_load: assert property (p_phase_load)
      else $error("Counter did not take phase at primary match");

   property p_cur_reset;
      ce && resetReq && !syncLoad |=> cnt_q == '0;
   endproperty
   a_cur_reset: assert property (p_cur_reset)
      else $error("Current reset did not restart the counter");

   property p_fault_data;
      ce && faultAct |=> highSideOutput == $past(ctrl_q.faultData[1])
         && lowSideOutput == $past(ctrl_q.faultData[0]);
   endproperty
   a_fault_data: assert property (p_fault_data)
      else $error("Fault did not drive the fault data");

   property p_limit_cut;
      ce && clAct && !faultAct
         |=> clTrunc_q && highSideOutput == $past(ctrl_q.faultData[1]);
   endproperty
   a_limit_cut: assert property (p_limit_cut)
      else $error("Current limit did not end the pulse");

   property p_rsv_mode;
      ce && !ovr && ctrl_q.pairMode == PWMG_PAIR_RSV
         |=> !highSideOutput && !lowSideOutput;
   endproperty
   a_rsv_mode: assert property (p_rsv_mode)
      else $error("Reserved pair mode drove an output");

   c_pp: cover property (ce && ctrl_q.pairMode == PWMG_PAIR_PP
                         && cycStart ##[1:300] lowSideOutput);
   c_trunc: cover property (clAct && pwmRaw);
   c_blank: cover property (blankTrig ##1 blanking && clSync);
   c_reset: cover property (resetReq);
   c_fault: cover property (faultAct ##1 highSideOutput);
endmodule

`default_nettype wire

// ### test/pwmg_sense.sv
// Current-sense comparator model that ends the channel's off-time
`timescale 1ns/10ps
`default_nettype none

module pwmg_sense (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       senseEn,
   input  wire logic [3:0] dischargeCyc,
   input  wire logic       highSide,
   output var  logic       curResetPin
);
   logic       highSeen_q;
   logic [3:0] left_q;

   // The inductor empties a fixed time after the switch opens, so the
   // reset only ever follows a deasserted pulse
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         highSeen_q <= 1'b0;
         left_q <= 4'h0;
         curResetPin <= 1'b0;
      end else begin
         highSeen_q <= highSide;
         if (senseEn && highSeen_q && !highSide)
            left_q <= dischargeCyc;
         else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
         curResetPin <= (left_q == 4'h1);
      end
   end
endmodule

`default_nettype wire

// ### test/pwmg_gen_tb.sv
// Self-checking bench for the PWM channel with edge blanking
`timescale 1ns/10ps
`default_nettype none
`include "pwmg_cfg.svh"

module pwmg_gen_tb;
   import pwmg_pkg::*;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] datW = 32'h0;
   logic [31:0] datR;
   logic        ack;
   logic        ptmrMatch = 1'b0;
   logic        faultPin = 1'b0;
   logic        curLimitPin = 1'b0;
   logic        curResetPin;
   logic        highOut;
   logic        lowOut;
   logic        senseEn = 1'b0;
   logic        ce = 1'b1;
   int          err_total = 0;
   int          checks_done = 0;
   int          hi, lo, eq, rises;
   // Limit rows first, then fault rows; blanking spans three and a half periods
   pwmg_cnt_t   rowBlank[11] = '{16'h0000, 16'h87F8, 16'h47F8, 16'h27F8,
      16'h17F8, 16'h07F8, 16'h8400, 16'h8BF8, 16'h0000, 16'h8BF8, 16'h87F8};
   int          rowHi[11] = '{0, 12, 12, 12, 12, 0, 0, 0, 24, 12, 24};
   int          rowLo[11] = '{24, 12, 12, 12, 12, 24, 24, 24, 0, 12, 0};
   int          modeHi[4] = '{12, 12, 6, 0};
   int          modeEq[4] = '{0, 24, 12, 24};

   always #25 sys_clk = ~sys_clk;

   pwmg_gen dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
      .ptmrMatch(ptmrMatch), .faultPin(faultPin),
      .curLimitPin(curLimitPin), .curResetPin(curResetPin),
      .highSideOutput(highOut), .lowSideOutput(lowOut));

   pwmg_sense sense (.sys_clk(sys_clk), .arst_n(arst_n), .senseEn(senseEn),
      .dischargeCyc(4'h4), .highSide(highOut), .curResetPin(curResetPin));

   task automatic fail(input string msg);
      err_total++;
      $display("Error at %0t: %s", $time, msg);
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmpVal(input pwmg_cnt_t got, input pwmg_cnt_t exp);
      checks_done++;
      if (got !== exp)
         fail($sformatf("register read %h, expected %h", got, exp));
   endtask

   task automatic cmpCnt(input int got, input int exp);
      checks_done++;
      if (got != exp)
         fail($sformatf("output count %0d, expected %0d", got, exp));
   endtask

   // Request held until ack is sampled high at a rising edge
   task automatic wbXfer(input logic w, input logic [7:0] a,
                         input pwmg_cnt_t d, output pwmg_cnt_t q);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h3;
      datW <= {16'h0000, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = datR[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 40)
         fail("no bus answer");
   endtask

   task automatic wr(input logic [7:0] a, input pwmg_cnt_t d);
      pwmg_cnt_t q;
      wbXfer(1'b1, a, d, q);
   endtask

   task automatic rdCmp(input logic [7:0] a, input pwmg_cnt_t exp);
      pwmg_cnt_t q;
      wbXfer(1'b0, a, 16'h0000, q);
      cmpVal(q, exp);
   endtask

   // With toLow the window is stretched until the pulse in flight ends
   task automatic measure(input int n, input logic toLow);
      logic last;
      int k;
      hi = 0;
      lo = 0;
      eq = 0;
      rises = 0;
      last = highOut;
      k = 0;
      while (k < n || (toLow && last === 1'b1 && k < n + 64)) begin
         @(negedge sys_clk);
         hi += (highOut === 1'b1);
         lo += (lowOut === 1'b1);
         eq += (highOut === lowOut);
         rises += (highOut === 1'b1 && last !== 1'b1);
         last = highOut;
         k++;
      end
   endtask

   task automatic waitLow();
      int k;
      k = 0;
      @(negedge sys_clk);
      while (highOut !== 1'b0 && k < 100) begin
         @(negedge sys_clk);
         k++;
      end
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail("watchdog expired");
      complete_run();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      cmpCnt(highOut === 1'b0 && lowOut === 1'b0, 1);
      rdCmp(`PWMG_A_BLANK, 16'h0000);
      rdCmp(`PWMG_A_PERIOD, 16'hFFFF);
      rdCmp(`PWMG_A_CTRL, 16'h0000);
      wr(`PWMG_A_BLANK, 16'hFFFF);
      rdCmp(`PWMG_A_BLANK, 16'hFFF8);
      wr(8'h1C, 16'h1234);
      rdCmp(8'h1C, 16'h0000);
      wr(`PWMG_A_BLANK, 16'h0000);
      $display("Test registers done");
      wr(`PWMG_A_PERIOD, 16'h0004);
      wr(`PWMG_A_DUTY, 16'h0002);
      for (int m = 0; m < 4; m++) begin
         wr(`PWMG_A_CTRL, {13'h0000, 2'(m), 1'b1});
         repeat (12) @(posedge sys_clk);
         measure(24, 1'b0);
         cmpCnt(hi, modeHi[m]);
         cmpCnt(lo, modeHi[m]);
         cmpCnt(eq, modeEq[m]);
      end
      $display("Test pair modes done");
      for (int i = 0; i < 11; i++) begin
         wr(`PWMG_A_CTRL, i < 8 ? 16'h0121 : 16'h0281);
         wr(`PWMG_A_BLANK, rowBlank[i]);
         repeat (12) @(posedge sys_clk);
         if (i < 8)
            curLimitPin <= 1'b1;
         else
            faultPin <= 1'b1;
         repeat (6) @(posedge sys_clk);
         measure(24, 1'b0);
         cmpCnt(hi, rowHi[i]);
         cmpCnt(lo, rowLo[i]);
         @(posedge sys_clk);
         curLimitPin <= 1'b0;
         faultPin <= 1'b0;
      end
      wr(`PWMG_A_BLANK, 16'h0000);
      $display("Test blanking done");
      wr(`PWMG_A_PERIOD, 16'h0028);
      wr(`PWMG_A_CTRL, 16'h0041);
      senseEn <= 1'b1;
      repeat (20) @(posedge sys_clk);
      waitLow();
      measure(126, 1'b1);
      cmpCnt(rises > 5, 1);
      cmpCnt(hi, 3 * rises);
      cmpCnt(eq, 0);
      @(posedge sys_clk);
      senseEn <= 1'b0;
      $display("Test current reset done");
      waitLow();
      wr(`PWMG_A_PHASE, 16'h0004);
      wr(`PWMG_A_CTRL, 16'h0011);
      measure(60, 1'b0);
      cmpCnt(rises >= 8, 1);
      @(posedge sys_clk);
      ce <= 1'b0;
      measure(20, 1'b0);
      cmpCnt(hi % 20, 0);
      cmpCnt(eq, 0);
      @(posedge sys_clk);
      ce <= 1'b1;
      $display("Test independent time base done");
      wr(`PWMG_A_CTRL, 16'h0009);
      wr(`PWMG_A_DUTY, 16'h000A);
      for (int i = 0; i < 2; i++) begin
         waitLow();
         wr(`PWMG_A_PHASE, i ? 16'h0008 : 16'h0000);
         @(posedge sys_clk);
         ptmrMatch <= 1'b1;
         @(posedge sys_clk);
         ptmrMatch <= 1'b0;
         @(negedge sys_clk);
         measure(20, 1'b0);
         cmpCnt(hi, i ? 3 : 11);
         cmpCnt(eq, 0);
      end
      $display("Test phase shift done");
      complete_run();
   end
endmodule

`default_nettype wire
